// file: rtl/mcu_interrupt_request_logic.sv
// What this block does
// - accept nmi, external, strobe, capture, compare, wrap, serial and soft trap requests
// - serial flags share one request when any enabled flag is set
// - soft trap starts an entry sequence regardless of any mask
// - entry lasts 12 cycles, restore lasts 10 cycles
// - non-maskable request has the highest service priority
// - non-maskable request only on a falling edge, steady low gives nothing
// - port strobe and capture requests are edge latched
// - external, compare, wrap and serial sources are level sensitive, served only while asserted
// - no internal mask exists for the non-maskable request
// - falling edges on nmi during reset are ignored
// - an nmi edge right after reset is served before the first instruction
// - after cycle 10 of an nmi entry a new edge may nest
// - shared nmi line held low raises no further request
// - external maskable request wins over internal maskable request
// - global mask bit inhibits all maskable requests when set
// - global mask is set by reset and by every entry sequence
// - each request line is sampled and synchronised before it sets pending
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

module mcu_interrupt_request_logic (
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,

  // avalon-mm slave
  input  wire logic [3:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,

  // request lines
  input  wire logic             nmi_n_i,
  input  wire logic             external_maskable_request_n_i,
  input  wire irq_pkg::periph_flags_t periph_i,

  // cpu sequencer
  input  wire logic             instr_boundary_i,
  input  wire logic             soft_trap_instruction_i,
  input  wire logic             rti_i,
  input  wire logic             mask_set_i,
  input  wire logic             mask_clear_i,

  // service outputs
  output logic                  service_start_o,
  output irq_pkg::src_t         service_source_o,
  output logic                  entry_busy_o,
  output logic                  restore_busy_o,
  output logic                  global_mask_o,
  output logic                  nmi_pending_o
);
  import irq_pkg::*;

  localparam int NL = `IRQ_NUM_LINES;
  localparam logic [NL-1:0] LINE_IDLE = `IRQ_LINE_IDLE;

  // raw request lines, gathered in synchroniser order
  wire logic [NL-1:0] raw_lines;
  wire logic [NL-1:0] s2_lines;
  wire logic [NL-1:0] s3_lines;

  assign raw_lines = {
    nmi_n_i,
    external_maskable_request_n_i,
    periph_i.port3_strobe_flag,
    periph_i.capture_flag,
    periph_i.compare_flag,
    periph_i.counter_wrap_flag,
    periph_i.rx_full_flag,
    periph_i.rx_overrun_framing_flag,
    periph_i.tx_empty_flag
  };

  // two-stage synchroniser plus one history stage per line;
  // reset loads the idle level so no edge is seen during reset
  genvar g;
  for (g = 0; g < NL; g++) begin : g_sync
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_r <= LINE_IDLE[g];
        s2_r <= LINE_IDLE[g];
        s3_r <= LINE_IDLE[g];
      end else if (ce_i) begin
        s1_r <= raw_lines[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end
    assign s2_lines[g] = s2_r;
    assign s3_lines[g] = s3_r;
  end

  // registers
  logic [6:0]  ctrl_r;
  logic        mask_r;
  logic        mask_nxt;
  logic        nmi_pend_r;
  logic        nmi_pend_nxt;
  logic        trap_pend_r;
  logic        trap_pend_nxt;
  logic        strobe_pend_r;
  logic        strobe_pend_nxt;
  logic        capture_pend_r;
  logic        capture_pend_nxt;
  state_t      state_r;
  state_t      state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  src_t        cur_src_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        start_r;
  logic        entry_busy_r;
  logic        restore_busy_r;

  // edge detection on synchronised samples
  wire logic nmi_fall;
  wire logic strobe_rise;
  wire logic capture_rise;
  wire logic nmi_block;
  wire logic nmi_set;

  assign nmi_fall = s3_lines[`IRQ_B_NMI] & ~s2_lines[`IRQ_B_NMI];
  assign strobe_rise = s2_lines[`IRQ_B_STROBE] & ~s3_lines[`IRQ_B_STROBE];
  assign capture_rise = s2_lines[`IRQ_B_CAPTURE] & ~s3_lines[`IRQ_B_CAPTURE];

  // edges during the first ten cycles of an nmi entry are dropped
  assign nmi_block = (state_r == ST_ENTRY) & (cur_src_r == SRC_NMI) &
                     (cnt_r < `IRQ_NMI_REARM);
  assign nmi_set = nmi_fall & ~nmi_block;

  // level sources; compare, wrap and serial are gated by their enables
  wire logic ext_lv;
  wire logic compare_lv;
  wire logic wrap_lv;
  wire logic serial_lv;
  wire logic internal_any;

  assign ext_lv = ~s2_lines[`IRQ_B_EXT];
  assign compare_lv = s2_lines[`IRQ_B_COMPARE] & ctrl_r[`IRQ_C_COMPARE_EN];
  assign wrap_lv = s2_lines[`IRQ_B_WRAP] & ctrl_r[`IRQ_C_WRAP_EN];
  assign serial_lv = ((s2_lines[`IRQ_B_RXF] | s2_lines[`IRQ_B_RXO]) & ctrl_r[`IRQ_C_RX_EN]) |
                     (s2_lines[`IRQ_B_TXE] & ctrl_r[`IRQ_C_TX_EN]);
  assign internal_any = capture_pend_r | compare_lv | wrap_lv | serial_lv;

  // arbitration at an instruction boundary
  wire logic at_boundary;
  wire logic take_rti;
  wire logic trap_req;
  wire logic open_mask;
  src_t      sel_src;
  wire logic start;

  assign at_boundary = (state_r == ST_RUN) & instr_boundary_i;
  assign take_rti = at_boundary & rti_i;
  assign trap_req = trap_pend_r | (at_boundary & soft_trap_instruction_i);
  assign open_mask = ~mask_r;

  // nmi is never gated by the mask: no term of it reads mask_r
  assign sel_src = nmi_pend_r                     ? SRC_NMI :
                   trap_req                       ? SRC_TRAP :
                   (open_mask & ext_lv)           ? SRC_EXT :
                   (open_mask & strobe_pend_r)    ? SRC_STROBE :
                   (open_mask & capture_pend_r)   ? SRC_CAPTURE :
                   (open_mask & compare_lv)       ? SRC_COMPARE :
                   (open_mask & wrap_lv)          ? SRC_WRAP :
                   (open_mask & serial_lv)        ? SRC_SERIAL :
                   SRC_NONE;

  // a return takes the boundary; pending requests wait for the next one
  assign start = at_boundary & ~rti_i & (sel_src != SRC_NONE);

  wire logic take_nmi;
  wire logic take_trap;
  wire logic take_strobe;
  wire logic take_capture;

  assign take_nmi = start & (sel_src == SRC_NMI);
  assign take_trap = start & (sel_src == SRC_TRAP);
  assign take_strobe = start & (sel_src == SRC_STROBE);
  assign take_capture = start & (sel_src == SRC_CAPTURE);

  // pending latches: a new nmi, strobe or capture set wins over the clear of the same cycle; a taken trap clears trap pending
  assign nmi_pend_nxt = nmi_set | (nmi_pend_r & ~take_nmi);
  assign trap_pend_nxt = trap_req & ~take_trap;
  assign strobe_pend_nxt = (strobe_rise & ctrl_r[`IRQ_C_STROBE_EN]) |
                           (strobe_pend_r & ~take_strobe);
  assign capture_pend_nxt = (capture_rise & ctrl_r[`IRQ_C_CAPTURE_EN]) |
                            (capture_pend_r & ~take_capture);

  // bus decode
  wire logic bus_req;
  wire logic bus_done;
  wire logic hit_ctrl;
  wire logic hit_status;
  wire logic ctrl_wr;
  wire logic [31:0] status_word;
  wire logic [31:0] rd_mux;
  wire logic [1:0]  state_bits;

  assign bus_req = avs_read_i | avs_write_i;
  assign bus_done = bus_req & ~wait_r;
  assign hit_ctrl = (avs_address_i == `IRQ_CTRL_ADDR);
  assign hit_status = (avs_address_i == `IRQ_STATUS_ADDR);
  assign ctrl_wr = avs_write_i & bus_done & hit_ctrl & avs_byteenable_i[0];
  assign state_bits = state_r;
  assign status_word = {19'h0, mask_r, cur_src_r, state_bits, internal_any, ext_lv,
                        capture_pend_r, strobe_pend_r, trap_pend_r, nmi_pend_r};
  assign rd_mux = hit_ctrl   ? {25'h0, ctrl_r[6:1], mask_r} :
                  hit_status ? status_word :
                  32'h0;

  // global mask: entry and reset set it, above every other source
  assign mask_nxt = start        ? 1'b1 :
                    mask_set_i   ? 1'b1 :
                    ctrl_wr      ? avs_writedata_i[`IRQ_C_MASK] :
                    mask_clear_i ? 1'b0 :
                    mask_r;

  // sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      ST_RUN: begin
        if (take_rti) begin
          state_nxt = ST_RESTORE;
          cnt_nxt = 4'd0;
        end else if (start) begin
          state_nxt = ST_ENTRY;
          cnt_nxt = 4'd0;
        end
      end
      ST_ENTRY: begin
        if (cnt_r == `IRQ_ENTRY_CYCLES - 4'd1) begin
          state_nxt = ST_RUN;
          cnt_nxt = 4'd0;
        end else begin
          cnt_nxt = cnt_r + 4'd1;
        end
      end
      ST_RESTORE: begin
        if (cnt_r == `IRQ_RESTORE_CYCLES - 4'd1) begin
          state_nxt = ST_RUN;
          cnt_nxt = 4'd0;
        end else begin
          cnt_nxt = cnt_r + 4'd1;
        end
      end
      default: begin
        state_nxt = ST_RUN;
        cnt_nxt = 4'd0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
      cnt_r <= 4'd0;
      cur_src_r <= SRC_NONE;
    end else if (ce_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (start) begin
        cur_src_r <= sel_src;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_pend_r <= 1'b0;
      trap_pend_r <= 1'b0;
      strobe_pend_r <= 1'b0;
      capture_pend_r <= 1'b0;
    end else if (ce_i) begin
      nmi_pend_r <= nmi_pend_nxt;
      trap_pend_r <= trap_pend_nxt;
      strobe_pend_r <= strobe_pend_nxt;
      capture_pend_r <= capture_pend_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= 1'b1;
      ctrl_r <= `IRQ_CTRL_RESET;
    end else if (ce_i) begin
      mask_r <= mask_nxt;
      if (ctrl_wr) begin
        ctrl_r <= avs_writedata_i[6:0];
      end
    end
  end

  // bus: one wait cycle, then the answer at the second edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if (ce_i) begin
      wait_r <= ~(bus_req & wait_r);
      if (avs_read_i & wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // registered service outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r <= 1'b0;
      entry_busy_r <= 1'b0;
      restore_busy_r <= 1'b0;
    end else if (ce_i) begin
      start_r <= start;
      entry_busy_r <= (state_nxt == ST_ENTRY);
      restore_busy_r <= (state_nxt == ST_RESTORE);
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign service_start_o = start_r;
  assign service_source_o = cur_src_r;
  assign entry_busy_o = entry_busy_r;
  assign restore_busy_o = restore_busy_r;
  assign global_mask_o = mask_r;
  assign nmi_pending_o = nmi_pend_r;

endmodule : mcu_interrupt_request_logic

`default_nettype wire

// file: rtl/irq_params.svh
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// sequence lengths in bus clock cycles
`define IRQ_ENTRY_CYCLES   4'd12
`define IRQ_RESTORE_CYCLES 4'd10
`define IRQ_NMI_REARM      4'd10

// register byte offsets
`define IRQ_CTRL_ADDR      4'h0
`define IRQ_STATUS_ADDR    4'h4

// control fields and reset value
`define IRQ_C_MASK         0
`define IRQ_C_STROBE_EN    1
`define IRQ_C_CAPTURE_EN   2
`define IRQ_C_COMPARE_EN   3
`define IRQ_C_WRAP_EN      4
`define IRQ_C_RX_EN        5
`define IRQ_C_TX_EN        6
`define IRQ_CTRL_RESET     7'h01

// synchroniser line positions and idle levels
`define IRQ_NUM_LINES      9
`define IRQ_LINE_IDLE      9'h180
`define IRQ_B_NMI          8
`define IRQ_B_EXT          7
`define IRQ_B_STROBE       6
`define IRQ_B_CAPTURE      5
`define IRQ_B_COMPARE      4
`define IRQ_B_WRAP         3
`define IRQ_B_RXF          2
`define IRQ_B_RXO          1
`define IRQ_B_TXE          0

`endif

// file: rtl/irq_pkg.sv
package irq_pkg;

  typedef struct packed {
    logic port3_strobe_flag;
    logic capture_flag;
    logic compare_flag;
    logic counter_wrap_flag;
    logic rx_full_flag;
    logic rx_overrun_framing_flag;
    logic tx_empty_flag;
  } periph_flags_t;

  typedef enum logic [3:0] {
    SRC_NONE,
    SRC_NMI,
    SRC_TRAP,
    SRC_EXT,
    SRC_STROBE,
    SRC_CAPTURE,
    SRC_COMPARE,
    SRC_WRAP,
    SRC_SERIAL
  } src_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTRY,
    ST_RESTORE
  } state_t;

endpackage : irq_pkg

// file: verif/irq_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module irq_checker (
  // clock and reset
  input wire logic           clk_i,
  input wire logic           rst_i,
  // watched inputs
  input wire logic           nmi_n_i,
  input wire logic           instr_boundary_i,
  input wire logic           soft_trap_instruction_i,
  input wire logic           rti_i,
  // watched outputs
  input wire logic           service_start_o,
  input wire irq_pkg::src_t  service_source_o,
  input wire logic           entry_busy_o,
  input wire logic           restore_busy_o,
  input wire logic           global_mask_o,
  input wire logic           nmi_pending_o
);
  import irq_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_entry;
    entry_busy_o[*8] ##1 entry_busy_o[*4] ##1 !entry_busy_o;
  endsequence
  sequence s_restore;
    restore_busy_o[*8] ##1 restore_busy_o[*2] ##1 !restore_busy_o;
  endsequence

  property p_entry_len;
    service_start_o |-> s_entry;
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry busy length wrong");
  property p_restore_len;
    instr_boundary_i && rti_i && !entry_busy_o && !restore_busy_o |=> s_restore;
  endproperty
  a_restore_len: assert property (p_restore_len) else $error("restore busy length wrong");
  property p_entry_mask;
    service_start_o |-> global_mask_o;
  endproperty
  a_entry_mask: assert property (p_entry_mask) else $error("mask not set on entry");
  property p_nmi_first;
    service_start_o && $past(nmi_pending_o) |-> service_source_o == SRC_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("pending nmi not served first");
  // a fresh pending needs a real high-to-low step, or a low line released from reset
  property p_nmi_edge;
    $rose(nmi_pending_o) |-> !$past(nmi_n_i, 3) && ($past(nmi_n_i, 4) || $past(rst_i, 4));
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi pending without falling edge");
  property p_masked;
    service_start_o && $past(global_mask_o) |-> service_source_o inside {SRC_NMI, SRC_TRAP};
  endproperty
  a_masked: assert property (p_masked) else $error("maskable source served under mask");
  property p_boundary;
    service_start_o |-> $past(instr_boundary_i) && !$past(entry_busy_o) && !$past(restore_busy_o);
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry started off a free boundary");
  property p_trap;
    service_start_o && $past(soft_trap_instruction_i) && !$past(nmi_pending_o) |-> service_source_o == SRC_TRAP;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not served");
endmodule : irq_checker

bind mcu_interrupt_request_logic irq_checker u_irq_checker (
  .clk_i(clk_i), .rst_i(rst_i), .nmi_n_i(nmi_n_i), .instr_boundary_i(instr_boundary_i),
  .soft_trap_instruction_i(soft_trap_instruction_i), .rti_i(rti_i), .service_start_o(service_start_o),
  .service_source_o(service_source_o), .entry_busy_o(entry_busy_o), .restore_busy_o(restore_busy_o),
  .global_mask_o(global_mask_o), .nmi_pending_o(nmi_pending_o)
);
`default_nettype wire

// file: verif/irq_peripherals.sv
`timescale 1ns/1ps
`default_nettype none
module irq_peripherals (
  // clock
  input  wire logic                    clk_i,
  // commands from the bench
  input  wire logic                    nmi_req_i,
  input  wire logic                    ext_req_i,
  input  wire irq_pkg::periph_flags_t  flags_i,
  // request lines; nmi and external are pulled up when idle
  output logic                         nmi_n_o = 1'b1,
  output logic                         ext_n_o = 1'b1,
  output irq_pkg::periph_flags_t       periph_o = '0
);
  // registered so every low phase lasts whole bus cycles, never a glitch
  always @(posedge clk_i) begin
    nmi_n_o  <= !nmi_req_i;
    ext_n_o  <= !ext_req_i;
    periph_o <= flags_i;
  end
endmodule : irq_peripherals
`default_nettype wire

// file: verif/test_mcu_interrupt_request_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_mcu_interrupt_request_logic;
  import irq_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          ce_i = 1'b1;
  logic [3:0]    avs_address_i = '0;
  logic          avs_read_i = 1'b0;
  logic          avs_write_i = 1'b0;
  logic [31:0]   avs_writedata_i = '0;
  logic [31:0]   avs_readdata_o;
  logic          avs_waitrequest_o;
  logic          nmi_req = 1'b0;
  logic          ext_req = 1'b0;
  periph_flags_t flags = '0;
  logic          nmi_n, ext_n;
  periph_flags_t periph;
  logic          instr_boundary_i = 1'b0;
  logic          soft_trap_instruction_i = 1'b0;
  logic          rti_i = 1'b0;
  logic          mask_set_i = 1'b0;
  logic          mask_clear_i = 1'b0;
  logic          service_start_o, entry_busy_o, restore_busy_o, global_mask_o, nmi_pending_o;
  src_t          service_source_o;
  logic [31:0]   q;
  int            bad_count = 0;
  int            cmp_count = 0;
  localparam logic [6:0] FL_TAB [9] = '{7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h6f, 7'h67, 7'h62, 7'h61, 7'h60};
  localparam src_t SRC_TAB [9] = '{SRC_EXT, SRC_STROBE, SRC_CAPTURE, SRC_COMPARE, SRC_WRAP,
                                   SRC_SERIAL, SRC_SERIAL, SRC_SERIAL, SRC_NONE};

  always #5 clk_i = !clk_i;

  mcu_interrupt_request_logic u_mcu_interrupt_request_logic (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .nmi_n_i(nmi_n),
    .external_maskable_request_n_i(ext_n), .periph_i(periph), .instr_boundary_i(instr_boundary_i),
    .soft_trap_instruction_i(soft_trap_instruction_i), .rti_i(rti_i), .mask_set_i(mask_set_i),
    .mask_clear_i(mask_clear_i), .service_start_o(service_start_o), .service_source_o(service_source_o),
    .entry_busy_o(entry_busy_o), .restore_busy_o(restore_busy_o), .global_mask_o(global_mask_o),
    .nmi_pending_o(nmi_pending_o));

  irq_peripherals u_irq_peripherals (
    .clk_i(clk_i), .nmi_req_i(nmi_req), .ext_req_i(ext_req), .flags_i(flags),
    .nmi_n_o(nmi_n), .ext_n_o(ext_n), .periph_o(periph));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  // one boundary; a nonzero c clears the mask the cycle before
  task automatic serve(input src_t e, input logic t, input logic r, input logic c);
    @(posedge clk_i);
    mask_clear_i <= c;
    @(posedge clk_i);
    mask_clear_i <= 1'b0;
    instr_boundary_i <= 1'b1;
    soft_trap_instruction_i <= t;
    rti_i <= r;
    @(posedge clk_i);
    instr_boundary_i <= 1'b0;
    soft_trap_instruction_i <= 1'b0;
    rti_i <= 1'b0;
    @(negedge clk_i);
    chk("start", 32'(e != SRC_NONE), service_start_o);
    chk("restore", 32'(r), restore_busy_o);
    if (e != SRC_NONE) chk("source", e, service_source_o);
  endtask : serve

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  initial begin
    wt(8);
    nmi_req <= 1'b1;
    wt(4);
    nmi_req <= 1'b0;
    wt(8);
    rst_i <= 1'b0;
    @(posedge clk_i);
    nmi_req <= 1'b1;
    @(negedge clk_i);
    chk("mask", 1, global_mask_o);
    chk("reset source", SRC_NONE, service_source_o);
    chk("reset pend", 0, nmi_pending_o);
    bus(1'b0, 4'h0, 0, q);
    chk("ctrl", 32'h1, q);
    bus(1'b1, 4'hc, 32'hff, q);
    bus(1'b0, 4'h8, 0, q);
    chk("unmapped", 0, q);
    serve(SRC_NMI, 1'b0, 1'b0, 1'b0);
    wt(14);
    chk("held low", 0, nmi_pending_o);
    nmi_req <= 1'b0;
    wt(3);
    nmi_req <= 1'b1;
    wt(5);
    nmi_req <= 1'b0;
    serve(SRC_NMI, 1'b1, 1'b0, 1'b0);
    @(posedge clk_i);
    nmi_req <= 1'b1;
    wt(14);
    chk("early fall", 0, nmi_pending_o);
    serve(SRC_TRAP, 1'b0, 1'b0, 1'b0);
    // release, then fall again so the edge lands in entry cycle 11
    @(posedge clk_i);
    nmi_req <= 1'b0;
    wt(6);
    nmi_req <= 1'b1;
    wt(5);
    chk("nested", 1, nmi_pending_o);
    serve(SRC_NMI, 1'b0, 1'b0, 1'b0);
    wt(13);
    serve(SRC_NONE, 1'b0, 1'b1, 1'b0);
    @(posedge clk_i);
    ext_req <= 1'b1;
    wt(12);
    serve(SRC_NONE, 1'b0, 1'b0, 1'b0);
    bus(1'b1, 4'h0, 32'h7e, q);
    bus(1'b0, 4'h0, 0, q);
    chk("ctrl", 32'h7e, q);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      ext_req <= (i == 0);
      flags <= FL_TAB[i];
      wt(4);
      serve(SRC_TAB[i], 1'b0, 1'b0, 1'b1);
      wt(13);
    end
    ext_req <= 1'b1;
    mask_set_i <= 1'b1;
    @(posedge clk_i);
    mask_set_i <= 1'b0;
    wt(4);
    serve(SRC_NONE, 1'b0, 1'b0, 1'b0);
    serve(SRC_TRAP, 1'b1, 1'b0, 1'b0);
    end_sim;
  end

  initial begin
    wt(3000);
    bad_count++;
    end_sim;
  end
endmodule : test_mcu_interrupt_request_logic
`default_nettype wire
